// ==== core/cfs_flag.sv ====
`timescale 1ns/100ps
// sticky write-one-to-clear flag bank; a set in the clear cycle wins
module cfs_flag #(
	parameter int W = 32,
	parameter logic [31:0] RST = 32'h0000_0000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flag_o
);
	logic [W-1:0] flag_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_q <= RST[W-1:0];
		end else begin
			flag_q <= (flag_q & ~clr_i) | set_i; // [RULE13]
		end
	end

	assign flag_o = flag_q;

	a_flag_sticky: assert property (@(posedge clk_i) // [RULE13]
		disable iff (rst_i) ((flag_q & ~clr_i) != '0)
		|=> ((flag_q & $past(flag_q & ~clr_i)) == $past(flag_q & ~clr_i)))
		else $error("sticky flag dropped without clear");
	a_flag_set_wins: assert property (@(posedge clk_i) // [RULE13]
		disable iff (rst_i) (set_i != '0)
		|=> ((flag_q & $past(set_i)) == $past(set_i)))
		else $error("set lost against clear");
endmodule

// ==== core/cfs_pkg.sv ====
package cfs_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] OFS_HARD = 8'h00;
	localparam logic [7:0] OFS_MEM = 8'h04;
	localparam logic [7:0] OFS_BUS = 8'h08;
	localparam logic [7:0] OFS_USAGE = 8'h0c;
	localparam logic [7:0] OFS_ADDR = 8'h10;
	localparam logic [7:0] OFS_PEND = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;

	// hard fault status fields
	localparam int HF_VECT = 1;
	localparam int HF_ESC = 30;
	// memory management fields
	localparam int MM_IACC = 0;
	localparam int MM_DACC = 1;
	localparam int MM_UNSTK = 3;
	localparam int MM_STK = 4;
	// bus fault fields
	localparam int BF_PREF = 0;
	localparam int BF_EXACT = 1;
	localparam int BF_INEXACT = 2;
	localparam int BF_UNSTK = 3;
	localparam int BF_STK = 4;
	localparam int BF_VALID = 7;
	// usage fault fields
	localparam int UF_UNDEF = 0;
	localparam int UF_STATE = 1;
	localparam int UF_RET = 2;
	localparam int UF_NO_COPROCESSOR_FLAG = 3;
	localparam int UF_UNAL = 8;
	localparam int UF_DIV = 9;
	// pending/mask fields (one per fault class)
	localparam int PF_HARD = 0;
	localparam int PF_MEM = 1;
	localparam int PF_BUS = 2;
	localparam int PF_USAGE = 3;

	localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
	localparam logic [31:0] RST_ADDR = 32'h0000_0000;
	localparam logic [3:0] RST_MASK = 4'h0;

	// fault event reports from the core paths
	typedef struct packed {
		logic fetch_err;      // bus error on instruction prefetch
		logic vector_err;     // bus error on vector table read
		logic data_exact_err; // precise data bus error
		logic data_inexact_err;
		logic stack_err;      // bus error while stacking
		logic unstack_err;    // bus error while unstacking
		logic [31:0] data_addr; // address requested by the instruction
	} cfs_bus_ev_t;

	typedef struct packed {
		logic priv_instr; // protection mismatch on instruction access
		logic priv_data;
		logic priv_stack;
		logic priv_unstack;
		logic no_exec;    // fetch from no_execute_attribute region
		logic coproc;
		logic undef_op;
		logic bad_state;
		logic bad_return;
		logic unaligned;
		logic div_zero;
	} cfs_core_ev_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} cfs_reg_req_t;

	typedef enum logic [1:0] {
		CFS_NONE = 2'b00,
		CFS_MEM = 2'b01,
		CFS_BUS = 2'b11,
		CFS_USAGE = 2'b10
	} cfs_class_t;

endpackage

// ==== core/cfs_top.sv ====
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Overview of operation
// [RULE1] bus errors on fetch, vector, data fault
// [RULE2] vector read error: hard fault, vector flag
// [RULE3] escalated configurable fault sets escalation flag
// [RULE4] protection mismatches: memory fault, four flags
// [RULE5] no-execute fetch flags instruction violation always
// [RULE6] five bus error kinds, own flags
// [RULE7] coprocessor and undefined opcode usage faults
// [RULE8] bad instruction set state: usage fault
// [RULE9] bad return, unaligned, divide zero flags
// [RULE10] address register valid while valid flag set
// [RULE11] unaligned fault records requested address
// [RULE12] bus status shows cause and validity
// [RULE13] flags sticky until software writes one
module cfs_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire cfs_pkg::cfs_bus_ev_t bus_ev_i,
	input wire cfs_pkg::cfs_core_ev_t core_ev_i,
	input wire logic [3:0] fault_enable_i,
	input wire logic mpu_enable_i,
	input wire cfs_pkg::cfs_reg_req_t req_i,
	output logic [31:0] rdata_o,
	output logic hard_fault_o,
	output logic [2:0] fault_take_o,
	output logic irq_o
);
	// fault_enable_i: bit 0 mem, 1 bus, 2 usage handler enabled
	logic [31:0] hard_set, mem_set, bus_set, usage_set;
	logic [31:0] hard_clr, mem_clr, bus_clr, usage_clr;
	logic [31:0] hard_q, mem_q, bus_q, usage_q;
	logic [31:0] fault_addr_q;
	logic [31:0] rdata_q;
	logic [3:0] pend_q, mask_q, pend_set;
	logic mem_ev, bus_ev, usage_ev, escalate, addr_capture;
	logic hard_fault_q;
	logic [2:0] take_q;
	cfs_pkg::cfs_class_t class_d;

	function automatic logic hit(input cfs_pkg::cfs_reg_req_t r,
		input logic [7:0] ofs);
		hit = r.wr && (r.addr == ofs);
	endfunction

	function automatic logic [31:0] w1c(input cfs_pkg::cfs_reg_req_t r,
		input logic [7:0] ofs);
		w1c = hit(r, ofs) ? r.wdata : 32'h0000_0000;
	endfunction

	// event classification
	always_comb begin
		mem_set = '0;
		bus_set = '0;
		usage_set = '0;
		hard_set = '0;
		// [RULE5] no-execute checked regardless of mpu_enable_i
		mem_set[cfs_pkg::MM_IACC] = (core_ev_i.priv_instr && mpu_enable_i)
			|| core_ev_i.no_exec; // [RULE4] [RULE5]
		mem_set[cfs_pkg::MM_DACC] = core_ev_i.priv_data && mpu_enable_i;
		mem_set[cfs_pkg::MM_STK] = core_ev_i.priv_stack && mpu_enable_i;
		mem_set[cfs_pkg::MM_UNSTK] = core_ev_i.priv_unstack && mpu_enable_i;
		bus_set[cfs_pkg::BF_PREF] = bus_ev_i.fetch_err; // [RULE1] [RULE6]
		bus_set[cfs_pkg::BF_EXACT] = bus_ev_i.data_exact_err; // [RULE6]
		bus_set[cfs_pkg::BF_INEXACT] = bus_ev_i.data_inexact_err; // [RULE6]
		bus_set[cfs_pkg::BF_STK] = bus_ev_i.stack_err; // [RULE6]
		bus_set[cfs_pkg::BF_UNSTK] = bus_ev_i.unstack_err; // [RULE6]
		// address is known only for a precise data error
		bus_set[cfs_pkg::BF_VALID] = bus_ev_i.data_exact_err; // [RULE12]
		usage_set[cfs_pkg::UF_NO_COPROCESSOR_FLAG] = core_ev_i.coproc; // [RULE7]
		usage_set[cfs_pkg::UF_UNDEF] = core_ev_i.undef_op; // [RULE7]
		usage_set[cfs_pkg::UF_STATE] = core_ev_i.bad_state; // [RULE8]
		usage_set[cfs_pkg::UF_RET] = core_ev_i.bad_return; // [RULE9]
		usage_set[cfs_pkg::UF_UNAL] = core_ev_i.unaligned; // [RULE9]
		usage_set[cfs_pkg::UF_DIV] = core_ev_i.div_zero; // [RULE9]
		mem_ev = |mem_set;
		bus_ev = |bus_set;
		usage_ev = |usage_set;
		// disabled configurable handler escalates to hard fault
		escalate = (mem_ev && !fault_enable_i[0])
			|| (bus_ev && !fault_enable_i[1])
			|| (usage_ev && !fault_enable_i[2]); // [RULE3]
		hard_set[cfs_pkg::HF_VECT] = bus_ev_i.vector_err; // [RULE1] [RULE2]
		hard_set[cfs_pkg::HF_ESC] = escalate; // [RULE3]
	end

	// priority: bus over memory over usage when several arrive at once
	always_comb begin
		if (bus_ev) begin
			class_d = cfs_pkg::CFS_BUS;
		end else if (mem_ev) begin
			class_d = cfs_pkg::CFS_MEM;
		end else if (usage_ev) begin
			class_d = cfs_pkg::CFS_USAGE;
		end else begin
			class_d = cfs_pkg::CFS_NONE;
		end
	end

	assign hard_clr = w1c(req_i, cfs_pkg::OFS_HARD);
	assign mem_clr = w1c(req_i, cfs_pkg::OFS_MEM);
	assign bus_clr = w1c(req_i, cfs_pkg::OFS_BUS);
	assign usage_clr = w1c(req_i, cfs_pkg::OFS_USAGE);

	cfs_flag #(.W(32), .RST(cfs_pkg::RST_FLAGS)) u_hard (
		.clk_i(clk_i), .rst_i(rst_i), .set_i(hard_set),
		.clr_i(hard_clr), .flag_o(hard_q));
	cfs_flag #(.W(32), .RST(cfs_pkg::RST_FLAGS)) u_mem (
		.clk_i(clk_i), .rst_i(rst_i), .set_i(mem_set),
		.clr_i(mem_clr), .flag_o(mem_q));
	cfs_flag #(.W(32), .RST(cfs_pkg::RST_FLAGS)) u_bus (
		.clk_i(clk_i), .rst_i(rst_i), .set_i(bus_set),
		.clr_i(bus_clr), .flag_o(bus_q));
	cfs_flag #(.W(32), .RST(cfs_pkg::RST_FLAGS)) u_usage (
		.clk_i(clk_i), .rst_i(rst_i), .set_i(usage_set),
		.clr_i(usage_clr), .flag_o(usage_q));

	// first captured address kept by later captures while valid stays set; a software write still replaces it
	assign addr_capture = bus_ev_i.data_exact_err
		&& !(bus_q[cfs_pkg::BF_VALID] && !bus_clr[cfs_pkg::BF_VALID]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_addr_q <= cfs_pkg::RST_ADDR;
		end else if (addr_capture) begin
			// requested address, not the split beat that failed
			fault_addr_q <= bus_ev_i.data_addr; // [RULE10] [RULE11]
		end else if (hit(req_i, cfs_pkg::OFS_ADDR)) begin
			fault_addr_q <= req_i.wdata;
		end
	end

	// fault outputs toward the exception logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hard_fault_q <= 1'b0;
			take_q <= 3'b000;
		end else begin
			hard_fault_q <= |hard_set; // [RULE2] [RULE3]
			// one class taken per cycle; a lower one keeps its flags
			take_q[0] <= (class_d == cfs_pkg::CFS_MEM)
				&& fault_enable_i[0]; // [RULE4]
			take_q[1] <= (class_d == cfs_pkg::CFS_BUS)
				&& fault_enable_i[1]; // [RULE1]
			take_q[2] <= (class_d == cfs_pkg::CFS_USAGE)
				&& fault_enable_i[2]; // [RULE7]
		end
	end

	assign hard_fault_o = hard_fault_q;
	assign fault_take_o = take_q;

	// interrupt status: read clears, set wins over the read
	always_comb begin
		pend_set = 4'h0;
		pend_set[cfs_pkg::PF_HARD] = |hard_set;
		pend_set[cfs_pkg::PF_MEM] = mem_ev;
		pend_set[cfs_pkg::PF_BUS] = bus_ev;
		pend_set[cfs_pkg::PF_USAGE] = usage_ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= 4'h0;
		end else if (req_i.rd && req_i.addr == cfs_pkg::OFS_PEND) begin
			pend_q <= pend_set;
		end else begin
			pend_q <= pend_q | pend_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= cfs_pkg::RST_MASK;
		end else if (hit(req_i, cfs_pkg::OFS_MASK)) begin
			mask_q <= req_i.wdata[3:0];
		end
	end

	assign irq_o = |(pend_q & mask_q);

	// register read port, data one cycle after strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (req_i.rd) begin
			unique case (req_i.addr)
				cfs_pkg::OFS_HARD: rdata_q <= hard_q;
				cfs_pkg::OFS_MEM: rdata_q <= mem_q;
				cfs_pkg::OFS_BUS: rdata_q <= bus_q; // [RULE12]
				cfs_pkg::OFS_USAGE: rdata_q <= usage_q;
				cfs_pkg::OFS_ADDR: rdata_q <= fault_addr_q; // [RULE10]
				cfs_pkg::OFS_PEND: rdata_q <= {28'h0000000, pend_q};
				cfs_pkg::OFS_MASK: rdata_q <= {28'h0000000, mask_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	assign rdata_o = rdata_q;

	// assertions
	default clocking chk_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_vector_hard: assert property ( // [RULE2]
		bus_ev_i.vector_err |=> (hard_q[cfs_pkg::HF_VECT] && hard_fault_o))
		else $error("vector error not reported as hard fault");

	a_escalate_flag: assert property ( // [RULE3]
		(bus_ev_i.fetch_err && !fault_enable_i[1])
		|=> (hard_q[cfs_pkg::HF_ESC] && !fault_take_o[1]))
		else $error("disabled bus fault not escalated");

	a_escalate_usage: assert property ( // [RULE3]
		(core_ev_i.coproc && !fault_enable_i[2])
		|=> (hard_q[cfs_pkg::HF_ESC] && hard_fault_o && !fault_take_o[2]))
		else $error("disabled usage fault not escalated");

	a_fetch_flag: assert property ( // [RULE1] [RULE6]
		bus_ev_i.fetch_err |=> bus_q[cfs_pkg::BF_PREF])
		else $error("prefetch bus error not flagged");

	a_noexec_iacc: assert property ( // [RULE5]
		core_ev_i.no_exec |=> mem_q[cfs_pkg::MM_IACC])
		else $error("no-execute fetch not flagged");

	a_mem_data_flag: assert property ( // [RULE4]
		(core_ev_i.priv_data && mpu_enable_i)
		|=> mem_q[cfs_pkg::MM_DACC])
		else $error("data protection mismatch not flagged");

	a_gated_priv: assert property ( // [RULE4]
		(core_ev_i.priv_data && !mpu_enable_i && !mem_q[cfs_pkg::MM_DACC])
		|=> !mem_q[cfs_pkg::MM_DACC])
		else $error("protection mismatch flagged while unit off");

	a_mem_unstack: assert property ( // [RULE4]
		(core_ev_i.priv_unstack && mpu_enable_i)
		|=> mem_q[cfs_pkg::MM_UNSTK])
		else $error("unstacking protection mismatch not flagged");

	a_bus_fault_take: assert property ( // [RULE1] [RULE6]
		(bus_ev_i.stack_err && fault_enable_i[1])
		|=> (fault_take_o[1] && bus_q[cfs_pkg::BF_STK]))
		else $error("stacking bus error not taken");

	a_bus_unstack: assert property ( // [RULE6]
		bus_ev_i.unstack_err |=> bus_q[cfs_pkg::BF_UNSTK])
		else $error("unstacking bus error not flagged");

	a_inexact_flag: assert property ( // [RULE6]
		bus_ev_i.data_inexact_err |=> bus_q[cfs_pkg::BF_INEXACT])
		else $error("imprecise bus error not flagged");

	a_usage_flags: assert property ( // [RULE7] [RULE8] [RULE9]
		(core_ev_i.div_zero |=> usage_q[cfs_pkg::UF_DIV])
		and (core_ev_i.bad_state |=> usage_q[cfs_pkg::UF_STATE])
		and (core_ev_i.coproc |=> usage_q[cfs_pkg::UF_NO_COPROCESSOR_FLAG]))
		else $error("usage fault flag missing");

	a_undef_flag: assert property ( // [RULE7]
		core_ev_i.undef_op |=> usage_q[cfs_pkg::UF_UNDEF])
		else $error("undefined opcode flag missing");

	a_unaligned_flag: assert property ( // [RULE9]
		core_ev_i.unaligned |=> usage_q[cfs_pkg::UF_UNAL])
		else $error("unaligned flag missing");

	a_return_flag: assert property ( // [RULE9]
		core_ev_i.bad_return |=> usage_q[cfs_pkg::UF_RET])
		else $error("bad return code flag missing");

	a_addr_capture: assert property ( // [RULE10] [RULE11]
		(bus_ev_i.data_exact_err && !bus_q[cfs_pkg::BF_VALID])
		|=> (bus_q[cfs_pkg::BF_VALID]
		&& fault_addr_q == $past(bus_ev_i.data_addr)))
		else $error("fault address not captured");

	a_addr_hold: assert property ( // [RULE10]
		(bus_q[cfs_pkg::BF_VALID] && !bus_clr[cfs_pkg::BF_VALID]
		&& !hit(req_i, cfs_pkg::OFS_ADDR)) |=> $stable(fault_addr_q))
		else $error("valid fault address overwritten");

	a_valid_exact: assert property ( // [RULE12]
		$rose(bus_q[cfs_pkg::BF_VALID]) |-> $past(bus_ev_i.data_exact_err))
		else $error("address valid set without precise error");

	a_read_bus: assert property ( // [RULE12]
		(req_i.rd && req_i.addr == cfs_pkg::OFS_BUS)
		|=> rdata_o == $past(bus_q))
		else $error("bus status read mismatch");

	a_rdata_idle: assert property (
		!req_i.rd |=> rdata_o == 32'h0000_0000)
		else $error("read data outside its cycle");

	a_take_single: assert property (
		$onehot0(fault_take_o))
		else $error("more than one fault class taken");

	a_pend_bus: assert property (
		bus_ev_i.fetch_err |=> pend_q[cfs_pkg::PF_BUS])
		else $error("bus fault pending bit missing");

	c_vector: cover property (bus_ev_i.vector_err ##1 hard_fault_o);
	c_escalate: cover property (escalate ##1 hard_fault_o);
	c_addr_clear: cover property (
		bus_q[cfs_pkg::BF_VALID] ##1 !bus_q[cfs_pkg::BF_VALID]);
	c_usage: cover property (usage_ev ##1 fault_take_o[2]);
	c_irq: cover property ($rose(irq_o));
endmodule

// ==== verif/cfs_core_model.sv ====
`timescale 1ns/100ps
// core paths: one event pulse per go; address lines churn after it
module cfs_core_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [4:0] sel_i,
	input wire logic [31:0] addr_i,
	output cfs_pkg::cfs_bus_ev_t bus_ev_o,
	output cfs_pkg::cfs_core_ev_t core_ev_o
);
	logic [16:0] ev_q = 17'h0;
	logic [31:0] addr_q = 32'h0;
	always_ff @(posedge clk_i) begin
		ev_q <= go_i ? 17'h1_0000 >> sel_i : 17'h0;
		// inverted each cycle so a stale address is wrong in the cycle after the pulse
		addr_q <= go_i ? addr_i : ~addr_q;
	end
	assign bus_ev_o = {ev_q[16:11], addr_q};
	assign core_ev_o = ev_q[10:0];
endmodule

// ==== verif/cfs_top_tb.sv ====
`timescale 1ns/100ps
module cfs_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic go = 1'b0;
	logic [4:0] sel = 5'h0;
	logic [31:0] ea = 32'h0;
	logic [3:0] fen = 4'hf;
	logic mpu = 1'b1;
	cfs_pkg::cfs_reg_req_t req = '0;
	cfs_pkg::cfs_bus_ev_t bus_ev;
	cfs_pkg::cfs_core_ev_t core_ev;
	logic [31:0] rdata_o;
	logic hard_fault_o;
	logic [2:0] fault_take_o;
	logic irq_o;
	logic [3:0] seen = 4'h0;
	logic seen_clr = 1'b0;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int bad_count = 0;
	int n_compared = 0;
	// event index order matches the model's pulse order
	logic [7:0] ofs_t[17] = '{cfs_pkg::OFS_BUS, cfs_pkg::OFS_HARD,
		cfs_pkg::OFS_BUS, cfs_pkg::OFS_BUS, cfs_pkg::OFS_BUS,
		cfs_pkg::OFS_BUS, cfs_pkg::OFS_MEM, cfs_pkg::OFS_MEM,
		cfs_pkg::OFS_MEM, cfs_pkg::OFS_MEM, cfs_pkg::OFS_MEM,
		cfs_pkg::OFS_USAGE, cfs_pkg::OFS_USAGE, cfs_pkg::OFS_USAGE,
		cfs_pkg::OFS_USAGE, cfs_pkg::OFS_USAGE, cfs_pkg::OFS_USAGE};
	int bit_t[17] = '{cfs_pkg::BF_PREF, cfs_pkg::HF_VECT,
		cfs_pkg::BF_EXACT, cfs_pkg::BF_INEXACT, cfs_pkg::BF_STK,
		cfs_pkg::BF_UNSTK, cfs_pkg::MM_IACC, cfs_pkg::MM_DACC,
		cfs_pkg::MM_STK, cfs_pkg::MM_UNSTK, cfs_pkg::MM_IACC,
		cfs_pkg::UF_NO_COPROCESSOR_FLAG, cfs_pkg::UF_UNDEF, cfs_pkg::UF_STATE,
		cfs_pkg::UF_RET, cfs_pkg::UF_UNAL, cfs_pkg::UF_DIV};

	cfs_core_model model_u (
		.clk_i(clk_i),
		.go_i(go),
		.sel_i(sel),
		.addr_i(ea),
		.bus_ev_o(bus_ev),
		.core_ev_o(core_ev)
	);
	cfs_top dut_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.bus_ev_i(bus_ev),
		.core_ev_i(core_ev),
		.fault_enable_i(fen),
		.mpu_enable_i(mpu),
		.req_i(req),
		.rdata_o(rdata_o),
		.hard_fault_o(hard_fault_o),
		.fault_take_o(fault_take_o),
		.irq_o(irq_o)
	);

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	task automatic check_sig(string nm, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk_i) rd_seen <= req.rd;
	always @(negedge clk_i) begin
		if (rd_seen)
			check_sig("rdata", exp_q.pop_front(), rdata_o & msk_q.pop_front());
	end
	// cleared through a strobe so the bench never races this process
	always @(posedge clk_i)
		seen <= seen_clr ? 4'h0 : (seen | {hard_fault_o, fault_take_o});

	task automatic wr(logic [7:0] a, logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_i);
		req.wr <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_i);
		req.rd <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic ev(int k, logic [31:0] a);
		sel <= k[4:0];
		ea <= a;
		go <= 1'b1;
		seen_clr <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		seen_clr <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	// upper nibble: taken outputs, lower: pending bit
	function automatic logic [7:0] cls(logic [7:0] o);
		case (o)
			cfs_pkg::OFS_HARD: return 8'h81;
			cfs_pkg::OFS_MEM: return 8'h12;
			cfs_pkg::OFS_BUS: return 8'h24;
			default: return 8'h48;
		endcase
	endfunction

	initial begin
		#1000000;
		bad_count++;
		final_report();
	end

	initial begin
		logic [31:0] a1;
		logic [31:0] a2;
		void'($urandom(74));
		a1 = $urandom();
		a2 = $urandom();
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wr(8'h1c, 32'hffff_ffff);
		for (int a = 0; a < 32; a += 4)
			rd(a[7:0], 32'h0, 32'hffff_ffff);
		for (int k = 0; k < 17; k++) begin
			logic [31:0] e;
			e = (32'h1 << bit_t[k]) | (k == 2 ? 32'h80 : 32'h0);
			ev(k, $urandom());
			rd(ofs_t[k], e, 32'hffff_ffff);
			rd(ofs_t[k], e, 32'hffff_ffff);
			wr(ofs_t[k], 32'hffff_ffff);
			rd(ofs_t[k], 32'h0, 32'hffff_ffff);
			rd(cfs_pkg::OFS_PEND, {24'h0, cls(ofs_t[k])}, 32'hf);
			check_sig("taken", {24'h0, cls(ofs_t[k]) >> 4}, {28'h0, seen});
		end
		ev(2, a1);
		ev(2, a2);
		rd(cfs_pkg::OFS_ADDR, a1, 32'hffff_ffff);
		rd(cfs_pkg::OFS_BUS, 32'h82, 32'hffff_ffff);
		wr(cfs_pkg::OFS_BUS, 32'h80);
		ev(2, a2);
		rd(cfs_pkg::OFS_ADDR, a2, 32'hffff_ffff);
		wr(cfs_pkg::OFS_ADDR, a1);
		rd(cfs_pkg::OFS_ADDR, a1, 32'hffff_ffff);
		wr(cfs_pkg::OFS_BUS, 32'hffff_ffff);
		mpu <= 1'b0;
		ev(7, a1);
		ev(10, a1);
		rd(cfs_pkg::OFS_MEM, 32'h1 << cfs_pkg::MM_IACC, 32'hffff_ffff);
		wr(cfs_pkg::OFS_MEM, 32'hffff_ffff);
		mpu <= 1'b1;
		fen <= 4'h0;
		ev(11, a1);
		check_sig("escalated", 32'h8, {28'h0, seen});
		ev(0, a1);
		rd(cfs_pkg::OFS_HARD, 32'h4000_0000, 32'h4000_0000);
		check_sig("escalated", 32'h8, {28'h0, seen});
		wr(cfs_pkg::OFS_HARD, 32'hffff_ffff);
		wr(cfs_pkg::OFS_USAGE, 32'hffff_ffff);
		wr(cfs_pkg::OFS_BUS, 32'hffff_ffff);
		fen <= 4'hf;
		rd(cfs_pkg::OFS_PEND, 32'h0, 32'h0);
		wr(cfs_pkg::OFS_MASK, 32'h4);
		rd(cfs_pkg::OFS_MASK, 32'h4, 32'hffff_ffff);
		ev(12, a2);
		check_sig("irq", 32'h0, {31'h0, irq_o});
		ev(0, a2);
		check_sig("irq", 32'h1, {31'h0, irq_o});
		rd(cfs_pkg::OFS_PEND, 32'hc, 32'hf);
		check_sig("irq", 32'h0, {31'h0, irq_o});
		repeat (4) @(posedge clk_i);
		final_report();
	end
endmodule
